//--- logic/bpa_pkg.sv
// package for the bidirectional port with analog select: register map and carriers
package bpa_pkg;
  localparam int BPA_WIDTH = 8;
  localparam int BPA_ADDR_W = 4;
  // register indices (byte address = index, plain port)
  localparam logic [3:0] BPA_ADDR_PIN_LEVEL = 4'h0;
  localparam logic [3:0] BPA_ADDR_OUTPUT_LATCH = 4'h1;
  localparam logic [3:0] BPA_ADDR_DIRECTION = 4'h2;
  localparam logic [3:0] BPA_ADDR_ANALOG_SELECT = 4'h3;
  localparam logic [3:0] BPA_ADDR_PIN_SELECT = 4'h4;
  // reset values: all inputs, analog selected
  localparam logic [7:0] BPA_RST_DIRECTION = 8'hff;
  localparam logic [7:0] BPA_RST_LATCH = 8'h00;
  // analog select exists on pins 7..2 only
  localparam logic [7:0] BPA_ANSEL_MASK = 8'hfc;
  localparam logic [7:0] BPA_RST_ANSEL = 8'hfc;
  // pin select fields
  localparam int BPA_SEL_PWM2B = 0;
  localparam int BPA_SEL_CC2 = 1;
  localparam int BPA_SEL_CC3 = 2;
  localparam int BPA_SEL_T3CLK = 3;
  localparam logic [7:0] BPA_SEL_MASK = 8'h0f;
  localparam logic [7:0] BPA_RST_SEL = 8'h0f;
  // pin positions of shared functions
  localparam int BPA_PIN_PWM2B = 0;
  localparam int BPA_PIN_T3CLK = 0;
  localparam int BPA_PIN_CC2 = 1;
  localparam int BPA_PIN_SCLK = 6;
  localparam int BPA_PIN_CC3 = 6;
  localparam int BPA_PIN_RX = 7;

  // one peripheral output request
  typedef struct packed {
    logic en;
    logic val;
  } bpa_drive_t;

  // register write request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } bpa_wr_t;
endpackage

//--- logic/bpa_port.sv
// eight-pin bidirectional port with direction, latch, analog select and pin muxing
`timescale 1ns/100ps
module bpa_port
  import bpa_pkg::*;
#(
  parameter int WIDTH = BPA_WIDTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  // peripheral outputs, highest priority first per pin
  input wire bpa_drive_t sclk_drive_i,
  input wire bpa_drive_t cc3_drive_i,
  input wire bpa_drive_t cc2_drive_i,
  input wire bpa_drive_t pwm2b_drive_i,
  // peripheral inputs, synchronised
  output logic sync_serial_clock_o,
  output logic async_receive_in_o,
  output logic timer3_clock_o,
  output logic cc2_capture_o,
  output logic cc3_capture_o,
  // alternate pin targets of remapped functions
  output bpa_drive_t pwm2b_alt_o,
  output bpa_drive_t cc2_alt_o,
  output bpa_drive_t cc3_alt_o,
  output logic pin_select_o
);

  // ==========================================================
  // registers
  logic [7:0] direction_c;
  logic [7:0] output_latch_c;
  logic [7:0] analog_select_c;
  // pin choice of remappable functions, a set bit picks the default pin
  logic [7:0] pin_sel;
  // three-stage chain, only stage two ever reads stage one
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  // synchronised pin levels, updated only when stages two and three agree
  logic [7:0] pin_level_c;
  // digital view of the pins, analog pins read as zero
  logic [7:0] digital_in;
  // next values of the registered outputs
  logic [7:0] next_pin_o;
  logic [7:0] next_pin_oe;
  logic [7:0] next_rdata;

  // one function decides per pin whether it is a digital input
  function automatic logic [7:0] bpa_digital_in(input logic [7:0] lvl, input logic [7:0] ans);
    bpa_digital_in = lvl & ~ans;
  endfunction

  // a new direction reaches the pin drivers one edge after the write
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      direction_c <= BPA_RST_DIRECTION;
    end else if (reg_wr_i && reg_addr_i == BPA_ADDR_DIRECTION) begin
      direction_c <= reg_wdata_i;
    end
  end

  // both latch and pin addresses write the latch so pin writes never hit pins directly
  // a read of the latch therefore always returns what software last wrote
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      output_latch_c <= BPA_RST_LATCH;
    end else if (reg_wr_i && (reg_addr_i == BPA_ADDR_OUTPUT_LATCH ||
                              reg_addr_i == BPA_ADDR_PIN_LEVEL)) begin
      output_latch_c <= reg_wdata_i;
    end
  end

  // pins 1 and 0 have no analog path, so their select bits stay zero
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      analog_select_c <= BPA_RST_ANSEL;
    end else if (reg_wr_i && reg_addr_i == BPA_ADDR_ANALOG_SELECT) begin
      analog_select_c <= reg_wdata_i & BPA_ANSEL_MASK;
    end
  end

  // select bits stand in for configuration fuses, so software may rewrite them
  // they come out of reset on the default pins
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_sel <= BPA_RST_SEL;
    end else if (reg_wr_i && reg_addr_i == BPA_ADDR_PIN_SELECT) begin
      pin_sel <= reg_wdata_i & BPA_SEL_MASK;
    end
  end

  // ==========================================================
  // input synchroniser
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // change counts once stages two and three agree, a one-cycle glitch is dropped
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_level_c <= 8'h00;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin_level_c[i] <= sync3[i];
        end
      end
    end
  end

  // ==========================================================
  // output enable follows direction only, peripherals never switch a driver on
  always_comb begin
    next_pin_oe = ~direction_c;
  end

  // output mux, priority per pin; a peripheral only wins while its pin is an output
  always_comb begin
    next_pin_o = output_latch_c;
    // serial clock outranks compare three on their shared pin
    if (sclk_drive_i.en && !direction_c[BPA_PIN_SCLK]) begin
      next_pin_o[BPA_PIN_SCLK] = sclk_drive_i.val;
    end else if (cc3_drive_i.en && pin_sel[BPA_SEL_CC3] && !direction_c[BPA_PIN_CC3]) begin
      next_pin_o[BPA_PIN_CC3] = cc3_drive_i.val;
    end
    // compare two and pwm b each own their pin alone, so no ranking is needed
    if (cc2_drive_i.en && pin_sel[BPA_SEL_CC2] && !direction_c[BPA_PIN_CC2]) begin
      next_pin_o[BPA_PIN_CC2] = cc2_drive_i.val;
    end
    if (pwm2b_drive_i.en && pin_sel[BPA_SEL_PWM2B] && !direction_c[BPA_PIN_PWM2B]) begin
      next_pin_o[BPA_PIN_PWM2B] = pwm2b_drive_i.val;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_o <= 8'h00;
    end else begin
      pin_o <= next_pin_o;
    end
  end

  // drivers stay off through reset so nothing fights the board before software decides
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_oe_o <= 8'h00;
    end else begin
      pin_oe_o <= next_pin_oe;
    end
  end

  // ==========================================================
  // peripheral inputs and alternate routes
  assign digital_in = bpa_digital_in(pin_level_c, analog_select_c);

  // clock input only in input direction, so the port never hears its own drive
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync_serial_clock_o <= 1'b0;
    end else begin
      sync_serial_clock_o <= direction_c[BPA_PIN_SCLK] & digital_in[BPA_PIN_SCLK];
    end
  end

  // receive is only seen once software makes the pin a digital input
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      async_receive_in_o <= 1'b0;
    end else begin
      async_receive_in_o <= direction_c[BPA_PIN_RX] & digital_in[BPA_PIN_RX];
    end
  end

  // timer clock is held low while the function sits on its alternate pin
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      timer3_clock_o <= 1'b0;
    end else begin
      timer3_clock_o <= pin_sel[BPA_SEL_T3CLK] & digital_in[BPA_PIN_T3CLK];
    end
  end

  // capture inputs follow the same pin choice as the compare outputs
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cc2_capture_o <= 1'b0;
    end else begin
      cc2_capture_o <= pin_sel[BPA_SEL_CC2] & digital_in[BPA_PIN_CC2];
    end
  end

  // capture three shares its pin with the serial clock input
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cc3_capture_o <= 1'b0;
    end else begin
      cc3_capture_o <= pin_sel[BPA_SEL_CC3] & digital_in[BPA_PIN_CC3];
    end
  end

  // alternate pins live outside this port, so the request is passed on registered
  // only the enable is gated; the value rides along unchanged
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pwm2b_alt_o <= '0;
    end else begin
      pwm2b_alt_o.en <= pwm2b_drive_i.en & ~pin_sel[BPA_SEL_PWM2B];
      pwm2b_alt_o.val <= pwm2b_drive_i.val;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cc2_alt_o <= '0;
    end else begin
      cc2_alt_o.en <= cc2_drive_i.en & ~pin_sel[BPA_SEL_CC2];
      cc2_alt_o.val <= cc2_drive_i.val;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cc3_alt_o <= '0;
    end else begin
      cc3_alt_o.en <= cc3_drive_i.en & ~pin_sel[BPA_SEL_CC3];
      cc3_alt_o.val <= cc3_drive_i.val;
    end
  end

  // tells the timer which pin carries its clock
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_select_o <= 1'b0;
    end else begin
      pin_select_o <= ~pin_sel[BPA_SEL_T3CLK];
    end
  end

  // ==========================================================
  // read path
  // decode on the raw address; the flop below holds the answer for one cycle
  always_comb begin
    case (reg_addr_i)
      BPA_ADDR_PIN_LEVEL: next_rdata = bpa_digital_in(pin_level_c, analog_select_c);
      BPA_ADDR_OUTPUT_LATCH: next_rdata = output_latch_c;
      BPA_ADDR_DIRECTION: next_rdata = direction_c;
      BPA_ADDR_ANALOG_SELECT: next_rdata = analog_select_c;
      BPA_ADDR_PIN_SELECT: next_rdata = pin_sel;
      default: next_rdata = 8'h00;
    endcase
  end

  // data are zero outside the answer cycle, so several slaves can be or-ed together
  // the cost is one extra flop stage of read latency
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

//--- bench/bpa_pins_model.sv
// board-side circuitry model for the port pins
`timescale 1ns/100ps
module bpa_pins_model (
  // port side
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  // board side
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_i
);
  // a pin that the port has released shows the board level, never the last drive
  assign pin_i = (pin_o & pin_oe_o) | (ext_i & ~pin_oe_o);
endmodule

//--- bench/bpa_port_checker.sv
// concurrent checks on the port block
`timescale 1ns/100ps
module bpa_port_checker
  import bpa_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // register port and pins
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic async_receive_in_o
);
  // ==========================================
  // shadow registers
  logic [7:0] dir_s, lat_s, ans_s;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      dir_s <= BPA_RST_DIRECTION;
      lat_s <= BPA_RST_LATCH;
      ans_s <= BPA_RST_ANSEL;
    end else if (reg_wr_i) begin
      if (reg_addr_i == BPA_ADDR_DIRECTION) dir_s <= reg_wdata_i;
      if (reg_addr_i < 4'h2) lat_s <= reg_wdata_i;
      if (reg_addr_i == BPA_ADDR_ANALOG_SELECT) ans_s <= reg_wdata_i & BPA_ANSEL_MASK;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_reset_released: assert property ($past(reset_i) |-> pin_oe_o == 8'h00)
    else $error("outputs enabled after reset");
  a_oe_follows_dir: assert property (!$past(reset_i) |-> pin_oe_o == ~$past(dir_s))
    else $error("output enable does not follow direction");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_latch_readback: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h1
    |-> reg_rdata_o == $past(lat_s)) else $error("latch readback wrong");
  a_dir_readback: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h2
    |-> reg_rdata_o == $past(dir_s)) else $error("direction readback wrong");
  a_ansel_readback: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h3
    |-> reg_rdata_o == $past(ans_s)) else $error("analog select readback wrong");
  a_pinsel_masked: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h4
    |-> reg_rdata_o[7:4] == 4'h0) else $error("pin select high bits set");
  a_unmapped_zero: assert property ($past(reg_rd_i) && $past(reg_addr_i) > 4'h4
    |-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_rx_gated: assert property (ans_s[7] [*8] |=> !async_receive_in_o)
    else $error("receive input seen while analog selected");
endmodule
bind bpa_port bpa_port_checker bpa_port_checker_i (.sys_clk_i, .reset_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pin_oe_o, .async_receive_in_o);

//--- bench/bpa_port_test.sv
// self-checking bench for the port block
`timescale 1ns/100ps
module bpa_port_test;
  import bpa_pkg::*;
  // ==========================================
  // stimulus and wiring
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] a = 4'h0;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] ext = 8'h00;
  logic [7:0] rdata, pin_i, pin_o, oe;
  logic sck, rx, t3, c2c, c3c, psel;
  bpa_drive_t sclk = '0, cc3 = '0, cc2 = '0, pwm = '0, pwm_alt, cc2_alt, cc3_alt;
  int miscompares = 0;
  int tests_run = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  bpa_port bpa_port_i (.sys_clk_i, .reset_i, .reg_addr_i(a), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .pin_i, .pin_o, .pin_oe_o(oe), .sclk_drive_i(sclk),
    .cc3_drive_i(cc3), .cc2_drive_i(cc2), .pwm2b_drive_i(pwm), .sync_serial_clock_o(sck),
    .async_receive_in_o(rx), .timer3_clock_o(t3), .cc2_capture_o(c2c), .cc3_capture_o(c3c),
    .pwm2b_alt_o(pwm_alt), .cc2_alt_o(cc2_alt), .cc3_alt_o(cc3_alt), .pin_select_o(psel));
  bpa_pins_model bpa_pins_model_i (.pin_o, .pin_oe_o(oe), .ext_i(ext), .pin_i);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge sys_clk_i);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] ad, input logic [7:0] exp);
    @(posedge sys_clk_i);
    a <= ad;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #5000 miscompares++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    ext <= 8'hbc;
    rdc(BPA_ADDR_DIRECTION, 8'hff);
    rdc(BPA_ADDR_ANALOG_SELECT, 8'hfc);
    rdc(BPA_ADDR_PIN_SELECT, 8'h0f);
    rdc(BPA_ADDR_PIN_LEVEL, 8'h00);
    chk(oe, 8'h00);
    chk({4'h0, psel, t3, c2c, c3c}, 8'h00);
    $display("test reset done");
    wrr(BPA_ADDR_OUTPUT_LATCH, 8'ha5);
    wrr(BPA_ADDR_DIRECTION, 8'hf0);
    idle(3);
    chk(oe, 8'h0f);
    chk(pin_o & oe, 8'h05);
    rdc(BPA_ADDR_OUTPUT_LATCH, 8'ha5);
    wrr(BPA_ADDR_ANALOG_SELECT, 8'h80);
    idle(8);
    rdc(BPA_ADDR_PIN_LEVEL, 8'h35);
    wrr(BPA_ADDR_PIN_LEVEL, 8'h1a);
    rdc(BPA_ADDR_OUTPUT_LATCH, 8'h1a);
    idle(3);
    chk(pin_o & oe, 8'h0a);
    wrr(BPA_ADDR_ANALOG_SELECT, 8'h00);
    idle(8);
    chk({7'h00, rx}, 8'h01);
    $display("test latch and direction done");
    wrr(BPA_ADDR_ANALOG_SELECT, 8'hfc);
    sclk <= 2'b11;
    cc3 <= 2'b10;
    wrr(BPA_ADDR_DIRECTION, 8'h30);
    idle(3);
    chk(pin_o & 8'h40, 8'h40);
    wrr(BPA_ADDR_DIRECTION, 8'hf0);
    wrr(BPA_ADDR_ANALOG_SELECT, 8'h00);
    ext <= 8'hfc;
    idle(8);
    chk({7'h00, sck}, 8'h01);
    @(posedge sys_clk_i);
    pwm <= 2'b11;
    idle(3);
    chk(pin_o & 8'h01, 8'h01);
    wrr(BPA_ADDR_PIN_SELECT, 8'h0e);
    idle(3);
    chk(pin_o & 8'h01, 8'h00);
    chk({6'h00, pwm_alt}, 8'h03);
    wrr(4'hf, 8'hff);
    rdc(4'hf, 8'h00);
    rdc(BPA_ADDR_DIRECTION, 8'hf0);
    $display("test peripherals and map done");
    wrr(BPA_ADDR_DIRECTION, 8'hff);
    ext <= 8'h43;
    idle(8);
    chk({5'h00, t3, c2c, c3c}, 8'h07);
    wrr(BPA_ADDR_DIRECTION, 8'hfd);
    cc2 <= 2'b10;
    idle(3);
    chk(pin_o & 8'h02, 8'h00);
    wrr(BPA_ADDR_PIN_SELECT, 8'h00);
    idle(3);
    chk(pin_o & 8'h02, 8'h02);
    chk({4'h0, cc2_alt, cc3_alt}, 8'h0a);
    chk({7'h00, psel}, 8'h01);
    chk({5'h00, t3, c2c, c3c}, 8'h00);
    $display("test pin select routes done");
    end_of_test();
  end
endmodule
